// *** core/spm_defines.vh ***
// Constants for the sleep and power manager: register offsets, field positions,
// reset values and timing counts.
// Assumes a 10 MHz system clock and a 32-bit Avalon-MM register bus.
`ifndef SPM_DEFINES_VH
`define SPM_DEFINES_VH

// ----------
// Register byte offsets
// ----------
`define SPM_OFS_SLEEP_CTRL     4'h0
`define SPM_OFS_CORE_CTRL      4'h4
`define SPM_OFS_PERIPH_GATE    4'h8
`define SPM_OFS_STATUS         4'hC

// ----------
// Field positions
// ----------
`define SPM_SC_ALLOW_BIT       0
`define SPM_SC_MODE_LSB        1
`define SPM_SC_MODE_MSB        2
`define SPM_CC_BOD_UNLOCK_BIT  5
`define SPM_CC_BOD_OFF_BIT     6
`define SPM_PG_WIDTH           6

// ----------
// Sleep mode encodings
// ----------
`define SPM_MODE_IDLE          2'h0
`define SPM_MODE_ADC_NR        2'h1
`define SPM_MODE_PWR_DOWN      2'h2
`define SPM_MODE_PWR_SAVE      2'h3

// ----------
// Reset values
// ----------
`define SPM_RST_SLEEP_CTRL     3'h0
`define SPM_RST_PERIPH_GATE    6'h00

// ----------
// Timing counts at 10 MHz
// ----------
`define SPM_CLK_MHZ            16'h000A
`define SPM_WAKE_HOLD_CYC      3'h4
`define SPM_BOD_UNLOCK_WIN     3'h4
`define SPM_BOD_ACT_DELAY      3'h3
`define SPM_BOD_ACT_LEN        3'h3
`define SPM_BOD_WAKE_US        16'h003C
`define SPM_BOD_WAKE_CYC       (`SPM_BOD_WAKE_US * `SPM_CLK_MHZ)

`endif

// *** core/spm_sync3.v ***
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous input; output changes once stages two and three agree.
`timescale 1ns/100ps
`default_nettype none
module spm_sync3
(
    input  wire       clk,
    input  wire       srst,
    input  wire       ce,
    input  wire       din,
    output reg        dout
);
    reg               s1;
    reg               s2;
    reg               s3;

    always @(posedge clk)
    begin
        if (srst)
        begin
            s1   <= 1'b0;
            s2   <= 1'b0;
            s3   <= 1'b0;
            dout <= 1'b0;
        end
        else if (ce)
        begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3)
            begin
                dout <= s3;
            end
        end
    end
endmodule
`default_nettype wire

// *** core/spm_delay_cnt.v ***
// Down counter used for the wake-up start-up delay.
// Assumes a load pulse with a count; done pulses one cycle when it expires.
`timescale 1ns/100ps
`default_nettype none
module spm_delay_cnt
(
    input  wire        clk,
    input  wire        srst,
    input  wire        ce,
    input  wire        load,
    input  wire [15:0] count,
    output reg         busy,
    output reg         done
);
    reg         [15:0] cnt;

    always @(posedge clk)
    begin
        if (srst)
        begin
            cnt  <= 16'h0000;
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (ce)
        begin
            done <= 1'b0;
            if (load)
            begin
                cnt  <= count;
                busy <= 1'b1;
            end
            else if (busy)
            begin
                if (cnt <= 16'h0001)
                begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                else
                begin
                    cnt <= cnt - 16'h0001;
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** core/spm_sleep_manager.v ***
// Sleep mode and clock domain power manager with Avalon-MM register slave.
// Assumes a 10 MHz clock, a core that pulses sleep_instr once per sleep
// instruction, and wake sources other than the timer 0 events already qualified by their own enables.
// Operation
// - Sleep starts only on a sleep instruction with sleep allow set.
// - Enabled interrupt wakes; core held four cycles beyond start-up time.
// - Core state is frozen, never cleared, across sleep and wake.
// - Reset during sleep wakes and restarts from the reset vector.
// - Mode 00 idle stops core and flash clocks only.
// - Idle or noise reduction entry starts a conversion if converter enabled.
// - Mode 01 stops I/O, core and flash clocks.
// - Noise reduction wakes only on its listed sources.
// - Mode 10 power-down stops oscillator and all generated clocks.
// - Power-down wakes only on its listed asynchronous sources.
// - Power-down wake waits the fuse-defined reset start-up time.
// - Mode 11 power-save keeps the asynchronous clock running.
// - Timer 0 events wake power-save only with their enables and global enable.
// - Brown-out detector off on power-down or power-save entry when armed, back on at wake.
// - Wake after brown-out off lasts about 60 us.
// - Brown-out sleep-off resets to zero, keeping the detector on.
// - Gate bit stops peripheral clock, freezes it and blocks its registers.
// - Clearing a gate bit resumes the peripheral from its frozen state.
// - Gating acts in active and idle; deeper modes stop those clocks anyway.
// - Sleep-off active three cycles after setting, clears three cycles later.
//
// Local design decisions: the Avalon-MM slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "spm_defines.vh"
module spm_sleep_manager
(
    input  wire        clk,
    input  wire        srst,
    input  wire        ce,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg  [1:0]  avs_response,
    input  wire        sleep_instr,
    input  wire [15:0] clock_source_fuses,
    input  wire        adc_enabled,
    input  wire        irq_pending,
    input  wire        adc_done_irq,
    input  wire        wdt_irq,
    input  wire        serial_start_irq,
    input  wire        async_timer_irq,
    input  wire        spm_ready_irq,
    input  wire        timer0_ovf_irq,
    input  wire        timer0_cmp_irq,
    input  wire [1:0]  timer0_irq_mask,
    input  wire        global_irq_en,
    input  wire        timer0_async_select,
    input  wire        ext_irq_line_a,
    input  wire        ext_irq_line_b,
    input  wire        pin_change_irq,
    input  wire        sys_reset_req,
    output reg         core_hold,
    output reg         core_reset_vector,
    output reg         core_clock_en,
    output reg         flash_clock_en,
    output reg         io_clock_en,
    output reg         adc_clock_en,
    output reg         async_clock_en,
    output reg         osc_en,
    output reg  [5:0]  periph_clock_en,
    output reg         adc_start_conv,
    output reg         brownout_detector_en,
    output reg         sleeping
);
    // ----------
    // States
    // ----------
    localparam [1:0] ST_RUN   = 2'h0;
    localparam [1:0] ST_SLEEP = 2'h1;
    localparam [1:0] ST_START = 2'h2;
    localparam [1:0] ST_HOLD  = 2'h3;

    reg        [1:0] state;
    reg        [1:0] mode;
    reg              sleep_allow_bit;
    reg        [1:0] sleep_mode_select;
    reg        [5:0] peripheral_clock_gate_reg;
    reg              brownout_sleep_unlock;
    reg        [2:0] unlock_cnt;
    reg        [2:0] arm_cnt;
    reg        [2:0] act_cnt;
    reg              brownout_sleep_off;
    reg              bod_was_off;
    reg        [2:0] hold_cnt;
    reg              ack;
    reg              reset_pending;
    wire             ext_a_s;
    wire             ext_b_s;
    wire             pin_chg_s;
    wire             wake;
    wire             dly_busy;
    wire             dly_done;
    reg              dly_load;
    reg       [15:0] dly_count;
    wire             req;
    wire             wr_lo;

    // ----------
    // Pin synchronisers
    // ----------
    // Level wake lines come from pins; the far side keeps them held until
    // the filter has seen them, so a short glitch never wakes the core.
    spm_sync3 u_sync_a (.clk(clk), .srst(srst), .ce(ce),
                        .din(ext_irq_line_a), .dout(ext_a_s));
    spm_sync3 u_sync_b (.clk(clk), .srst(srst), .ce(ce),
                        .din(ext_irq_line_b), .dout(ext_b_s));
    spm_sync3 u_sync_p (.clk(clk), .srst(srst), .ce(ce),
                        .din(pin_change_irq), .dout(pin_chg_s));

    spm_delay_cnt u_dly (.clk(clk), .srst(srst), .ce(ce), .load(dly_load),
                         .count(dly_count), .busy(dly_busy),
                         .done(dly_done));

    // ----------
    // Wake qualification per mode
    // ----------
    wire async_wake = wdt_irq | serial_start_irq | ext_a_s | ext_b_s
                      | pin_chg_s;
    wire t0_wake = global_irq_en & ((timer0_ovf_irq & timer0_irq_mask[0])
                   | (timer0_cmp_irq & timer0_irq_mask[1]));

    assign wake = (mode == `SPM_MODE_IDLE) ? irq_pending :
                  (mode == `SPM_MODE_ADC_NR) ?
                      (async_wake | adc_done_irq | async_timer_irq
                       | spm_ready_irq) :
                  (mode == `SPM_MODE_PWR_DOWN) ? async_wake :
                  (async_wake | (timer0_async_select & t0_wake));

    // ----------
    // Bus slave
    // ----------
    // One wait cycle per access keeps the read mux off the critical path.
    assign req   = avs_read | avs_write;
    assign wr_lo = avs_write & ack & avs_byteenable[0];

    always @(posedge clk)
    begin
        if (srst)
        begin
            ack             <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h00000000;
            avs_response    <= 2'h0;
        end
        else if (ce)
        begin
            ack             <= req & ~ack;
            avs_waitrequest <= ~(req & ~ack);
            avs_response    <= 2'h0;
            if (avs_read & ~ack)
            begin
                if (avs_address == `SPM_OFS_SLEEP_CTRL)
                    avs_readdata <= {29'h0, sleep_mode_select,
                                     sleep_allow_bit};
                else if (avs_address == `SPM_OFS_CORE_CTRL)
                    avs_readdata <= {25'h0, brownout_sleep_off,
                                     brownout_sleep_unlock, 5'h00};
                else if (avs_address == `SPM_OFS_PERIPH_GATE)
                    avs_readdata <= {26'h0, peripheral_clock_gate_reg};
                else if (avs_address == `SPM_OFS_STATUS)
                    avs_readdata <= {28'h0, bod_was_off, mode, sleeping};
                else
                begin
                    avs_readdata <= 32'h00000000;
                    avs_response <= 2'h2;
                end
            end
        end
    end

    // ----------
    // Control registers and timed brown-out sleep-off sequence
    // ----------
    always @(posedge clk)
    begin
        if (srst)
        begin
            sleep_allow_bit           <= 1'b0;
            sleep_mode_select         <= 2'h0;
            peripheral_clock_gate_reg <= `SPM_RST_PERIPH_GATE;
            brownout_sleep_unlock     <= 1'b0;
            unlock_cnt                <= 3'h0;
            arm_cnt                   <= 3'h0;
            act_cnt                   <= 3'h0;
            brownout_sleep_off        <= 1'b0;
        end
        else if (ce)
        begin
            if (wr_lo && avs_address == `SPM_OFS_SLEEP_CTRL)
            begin
                sleep_allow_bit   <= avs_writedata[`SPM_SC_ALLOW_BIT];
                sleep_mode_select <= avs_writedata[`SPM_SC_MODE_MSB:
                                                   `SPM_SC_MODE_LSB];
            end
            if (wr_lo && avs_address == `SPM_OFS_PERIPH_GATE)
                peripheral_clock_gate_reg <=
                    avs_writedata[`SPM_PG_WIDTH-1:0];
            if (unlock_cnt != 3'h0)
                unlock_cnt <= unlock_cnt - 3'h1;
            else
                brownout_sleep_unlock <= 1'b0;
            if (arm_cnt != 3'h0)
            begin
                arm_cnt <= arm_cnt - 3'h1;
                if (arm_cnt == 3'h1)
                begin
                    brownout_sleep_off <= 1'b1;
                    act_cnt            <= `SPM_BOD_ACT_LEN;
                end
            end
            else if (act_cnt != 3'h0)
            begin
                act_cnt <= act_cnt - 3'h1;
                if (act_cnt == 3'h1)
                    brownout_sleep_off <= 1'b0;
            end
            if (wr_lo && avs_address == `SPM_OFS_CORE_CTRL)
            begin
                if (avs_writedata[`SPM_CC_BOD_OFF_BIT] &&
                    avs_writedata[`SPM_CC_BOD_UNLOCK_BIT])
                begin
                    brownout_sleep_unlock <= 1'b1;
                    unlock_cnt            <= `SPM_BOD_UNLOCK_WIN;
                end
                else if (avs_writedata[`SPM_CC_BOD_OFF_BIT] &&
                         brownout_sleep_unlock)
                begin
                    brownout_sleep_unlock <= 1'b0;
                    unlock_cnt            <= 3'h0;
                    arm_cnt               <= `SPM_BOD_ACT_DELAY;
                end
            end
        end
    end

    // ----------
    // Sleep state machine
    // ----------
    always @*
    begin
        dly_load  = 1'b0;
        dly_count = 16'h0001;
        if (state == ST_SLEEP && (wake || sys_reset_req))
        begin
            dly_load = 1'b1;
            if (bod_was_off)
                dly_count = `SPM_BOD_WAKE_CYC;
            else if (mode == `SPM_MODE_PWR_DOWN ||
                     mode == `SPM_MODE_PWR_SAVE)
                dly_count = (clock_source_fuses == 16'h0000) ?
                            16'h0001 : clock_source_fuses;
        end
    end

    always @(posedge clk)
    begin
        if (srst)
        begin
            state         <= ST_RUN;
            mode          <= `SPM_MODE_IDLE;
            sleeping      <= 1'b0;
            bod_was_off   <= 1'b0;
            hold_cnt      <= 3'h0;
            reset_pending <= 1'b0;
            core_hold     <= 1'b0;
            core_reset_vector <= 1'b0;
            adc_start_conv    <= 1'b0;
        end
        else if (ce)
        begin
            adc_start_conv    <= 1'b0;
            core_reset_vector <= 1'b0;
            case (state)
            ST_RUN:
            begin
                // Without sleep allow the instruction simply retires.
                if (sleep_instr && sleep_allow_bit)
                begin
                    state       <= ST_SLEEP;
                    mode        <= sleep_mode_select;
                    sleeping    <= 1'b1;
                    core_hold   <= 1'b1;
                    bod_was_off <= brownout_sleep_off &&
                                   sleep_mode_select[1];
                    adc_start_conv <= adc_enabled &&
                                      !sleep_mode_select[1];
                end
            end
            ST_SLEEP:
            begin
                if (wake || sys_reset_req)
                begin
                    state         <= ST_START;
                    reset_pending <= sys_reset_req;
                end
            end
            ST_START:
            begin
                sleeping <= 1'b0;
                if (dly_done)
                begin
                    state    <= ST_HOLD;
                    hold_cnt <= `SPM_WAKE_HOLD_CYC;
                end
            end
            default:
            begin
                if (hold_cnt <= 3'h1)
                begin
                    state             <= ST_RUN;
                    core_hold         <= 1'b0;
                    bod_was_off       <= 1'b0;
                    core_reset_vector <= reset_pending;
                    reset_pending     <= 1'b0;
                end
                else
                    hold_cnt <= hold_cnt - 3'h1;
            end
            endcase
        end
    end

    // ----------
    // Clock domain enables
    // ----------
    // Enables are registered so each gate sees a clean level from a flop.
    wire in_sleep = (state == ST_SLEEP);
    wire deep     = in_sleep & mode[1];

    always @(posedge clk)
    begin
        if (srst)
        begin
            core_clock_en        <= 1'b1;
            flash_clock_en       <= 1'b1;
            io_clock_en          <= 1'b1;
            adc_clock_en         <= 1'b1;
            async_clock_en       <= 1'b1;
            osc_en               <= 1'b1;
            periph_clock_en      <= 6'h3F;
            brownout_detector_en <= 1'b1;
        end
        else if (ce)
        begin
            core_clock_en  <= !in_sleep;
            flash_clock_en <= !in_sleep;
            io_clock_en    <= !(in_sleep &&
                                mode != `SPM_MODE_IDLE);
            adc_clock_en   <= !deep;
            osc_en         <= !deep;
            async_clock_en <= !(in_sleep &&
                                mode == `SPM_MODE_PWR_DOWN);
            // Deeper modes override the gates; clearing a bit resumes the
            // frozen peripheral because its state is never reset here.
            periph_clock_en <= (in_sleep && mode != `SPM_MODE_IDLE) ?
                               6'h00 : ~peripheral_clock_gate_reg;
            brownout_detector_en <= !(in_sleep && bod_was_off);
        end
    end
endmodule
`default_nettype wire

// *** verif/spm_properties.sv ***
// Concurrent checks on the ports of the sleep manager.
// Assumes ce held high and the testbench as the only bus master.
`timescale 1ns/100ps
`default_nettype none
module spm_properties
(
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic        avs_waitrequest,
    input wire logic        sleep_instr,
    input wire logic        adc_enabled,
    input wire logic        irq_pending,
    input wire logic        sys_reset_req,
    input wire logic        core_hold,
    input wire logic        core_reset_vector,
    input wire logic        core_clock_en,
    input wire logic        flash_clock_en,
    input wire logic        io_clock_en,
    input wire logic        adc_clock_en,
    input wire logic        async_clock_en,
    input wire logic        osc_en,
    input wire logic        adc_start_conv,
    input wire logic        brownout_detector_en,
    input wire logic        sleeping
);
    // Shadow of the sleep control word, taken at the bus accept edge.
    logic [2:0] ctl;
    always_ff @(posedge clk)
        if (srst)
            ctl <= 3'h0;
        else if (avs_write && !avs_waitrequest && avs_address == 4'h0
                 && avs_byteenable[0])
            ctl <= avs_writedata[2:0];
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence enter_s;
        sleep_instr && ctl[0] && !sleeping;
    endsequence
    bus_one_wait_a: assert property ($rose(avs_read || avs_write)
        |=> !avs_waitrequest) else $error("bus answer late");
    sleep_entry_a: assert property (enter_s |=> sleeping && core_hold)
        else $error("sleep not entered");
    no_entry_a: assert property (sleep_instr && !ctl[0] && !sleeping
        |=> !sleeping) else $error("sleep entered without allow");
    idle_clk_a: assert property (enter_s and ctl[2:1] == 2'h0 |=> ##1
        !core_clock_en && !flash_clock_en && io_clock_en && adc_clock_en)
        else $error("idle clock set wrong");
    adcnr_clk_a: assert property (enter_s and ctl[2:1] == 2'h1 |=> ##1
        !core_clock_en && !io_clock_en && adc_clock_en)
        else $error("noise reduction clock set wrong");
    pdown_clk_a: assert property (enter_s and ctl[2:1] == 2'h2 |=> ##1
        !osc_en && !adc_clock_en && !async_clock_en)
        else $error("power-down clock set wrong");
    psave_clk_a: assert property (enter_s and ctl[2:1] == 2'h3 |=> ##1
        async_clock_en && !osc_en && !io_clock_en)
        else $error("power-save clock set wrong");
    conv_start_a: assert property (enter_s and !ctl[2] && adc_enabled
        |-> ##[1:3] adc_start_conv) else $error("no conversion start");
    idle_wake_a: assert property (sleeping && ctl[2:1] == 2'h0
        && $rose(irq_pending) |-> core_hold[*4] ##[1:12] !core_hold)
        else $error("idle wake timing wrong");
    bod_off_a: assert property (!brownout_detector_en |-> core_hold)
        else $error("detector off while running");
    reset_vec_a: assert property ($rose(sys_reset_req) && sleeping
        |-> ##[1:40] core_reset_vector) else $error("no reset vector");
endmodule
bind spm_sleep_manager spm_properties i_spm_properties (.*);
`default_nettype wire

// *** verif/spm_core_model.sv ***
// Behavioural processor core: issues sleep instructions, raises an interrupt.
// Assumes the sleep manager's core_hold and sleeping outputs.
`timescale 1ns/100ps
`default_nettype none
module spm_core_model
(
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic go,
    input  wire logic wake_en,
    input  wire logic sleeping,
    input  wire logic core_hold,
    output var  logic sleep_instr,
    output var  logic irq_pending
);
    logic [3:0] lag;
    // A stalled core cannot execute, so no instruction issues while held.
    always_ff @(posedge clk)
        sleep_instr <= !srst && go && !core_hold;
    always_ff @(posedge clk)
        if (srst || !sleeping)
            lag <= 4'h0;
        else if (lag != 4'hF)
            lag <= lag + 4'h1;
    // The request stays up until the core runs again.
    always_ff @(posedge clk)
        irq_pending <= !srst && wake_en
                       && (lag == 4'h5 || (irq_pending && core_hold));
endmodule
`default_nettype wire

// *** verif/spm_sleep_manager_test.sv ***
// Self-checking testbench for the sleep manager.
// Assumes the core model and the bound property checker.
`timescale 1ns/100ps
`default_nettype none
module spm_sleep_manager_test;
    logic clk, srst, go, wake_en, avs_read, avs_write, sleep_instr;
    logic adc_enabled, irq_pending, adc_done_irq, async_timer_irq;
    logic timer0_ovf_irq, global_irq_en, sys_reset_req, avs_waitrequest;
    logic core_hold, core_reset_vector, core_clock_en, flash_clock_en;
    logic io_clock_en, adc_clock_en, async_clock_en, osc_en;
    logic adc_start_conv, brownout_detector_en, sleeping, cv, rv;
    logic [1:0]  avs_response, rd_resp;
    logic [3:0]  avs_address;
    logic [4:0]  wk;
    logic [5:0]  periph_clock_en;
    logic [31:0] avs_writedata, avs_readdata, rd_val;
    int          error_cnt, cmp_count, n;
    spm_sleep_manager i_spm_sleep_manager
    (
        .clk, .srst, .ce(1'b1), .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
        .avs_waitrequest, .avs_response, .sleep_instr,
        .clock_source_fuses(16'h0008), .adc_enabled, .irq_pending,
        .adc_done_irq, .wdt_irq(wk[4]), .serial_start_irq(wk[0]),
        .async_timer_irq, .spm_ready_irq(async_timer_irq), .timer0_ovf_irq,
        .timer0_cmp_irq(timer0_ovf_irq), .timer0_irq_mask(2'h1),
        .global_irq_en,
        .timer0_async_select(1'b1), .ext_irq_line_a(wk[1]),
        .ext_irq_line_b(wk[2]), .pin_change_irq(wk[3]), .sys_reset_req,
        .core_hold, .core_reset_vector, .core_clock_en, .flash_clock_en,
        .io_clock_en, .adc_clock_en, .async_clock_en, .osc_en,
        .periph_clock_en, .adc_start_conv, .brownout_detector_en, .sleeping
    );
    spm_core_model i_spm_core_model
    (
        .clk, .srst, .go, .wake_en, .sleeping, .core_hold, .sleep_instr,
        .irq_pending
    );
    task automatic give_verdict;
        if (error_cnt == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] s, e);
        cmp_count++;
        if (s !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input int d);
        @(posedge clk);
        avs_write <= w;
        avs_read <= !w;
        avs_address <= a;
        avs_writedata <= d;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rd_val = avs_readdata;
        rd_resp = avs_response;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // The sleep-off bit must be armed a few cycles before the instruction.
    task automatic nap(input logic [1:0] m, input logic off);
        bus(1'b1, 4'h0, {m, 1'b1});
        if (off)
        begin
            bus(1'b1, 4'h4, 32'h60);
            bus(1'b1, 4'h4, 32'h40);
            step(2);
        end
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        while (sleeping !== 1'b1) @(posedge clk);
        step(3);
    endtask
    task automatic wake;
        n = 0;
        while (core_hold !== 1'b0)
        begin
            @(posedge clk);
            n++;
        end
        {wake_en, adc_done_irq, async_timer_irq} <= 3'h0;
        {timer0_ovf_irq, global_irq_en, sys_reset_req, wk} <= 8'h00;
        step(8);
    endtask
    always @(posedge clk)
    begin
        if (adc_start_conv === 1'b1) cv = 1'b1;
        if (core_reset_vector === 1'b1) rv = 1'b1;
    end
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #2000000;
        error_cnt++;
        give_verdict;
    end
    initial
    begin
        {srst, go, wake_en, avs_read, avs_write, adc_enabled} = 6'h21;
        {adc_done_irq, async_timer_irq, timer0_ovf_irq} = 3'h0;
        {global_irq_en, sys_reset_req, wk, avs_address} = 11'h000;
        avs_writedata = 32'h0;
        step(20);
        srst <= 1'b0;
        step(1);
        check("bod_en", brownout_detector_en, 1'b1);
        check("gate", periph_clock_en, 6'h3F);
        bus(1'b0, 4'h4, 0);
        check("sleep_off", rd_val[6], 1'b0);
        bus(1'b0, 4'h2, 0);
        check("unmapped", rd_val, 0);
        check("resp", rd_resp, 2'h2);
        bus(1'b1, 4'h0, 0);
        go <= 1'b1;
        step(1);
        go <= 1'b0;
        step(4);
        check("no_sleep", sleeping, 1'b0);
        bus(1'b1, 4'h8, 32'h15);
        step(3);
        check("gate", periph_clock_en, 6'h2A);
        for (int m = 0; m < 4; m++)
        begin
            cv = 1'b0;
            rv = 1'b0;
            adc_enabled <= (m != 1);
            nap(m[1:0], 1'b0);
            check("conv", cv, m == 0);
            check("clocks", {core_clock_en, flash_clock_en, io_clock_en,
                adc_clock_en, async_clock_en, osc_en},
                (m == 0) ? 6'h0F : (m == 1) ? 6'h07 :
                (m == 2) ? 6'h00 : 6'h02);
            if (m == 0)
                check("idle_gate", periph_clock_en, 6'h2A);
            if (m > 1)
            begin
                {adc_done_irq, timer0_ovf_irq} <= 2'h3;
                async_timer_irq <= (m == 2);
                step(20);
                check("asleep", sleeping, 1'b1);
            end
            case (m)
                0: wake_en <= 1'b1;
                1: adc_done_irq <= 1'b1;
                2: wk[1] <= 1'b1;
                default: global_irq_en <= 1'b1;
            endcase
            wake;
            check("wake_len", n >= (m > 1 ? 12 : 4) && n < 100, 1'b1);
            check("no_rvec", rv, 1'b0);
        end
        bus(1'b1, 4'h8, 0);
        step(3);
        check("gate", periph_clock_en, 6'h3F);
        for (int k = 0; k < 5; k++)
        begin
            nap(2'h2, 1'b0);
            wk[k] <= 1'b1;
            wake;
            check("pd_wake", n >= 12 && n < 100, 1'b1);
        end
        rv = 1'b0;
        nap(2'h2, 1'b0);
        sys_reset_req <= 1'b1;
        wake;
        check("rvec", rv, 1'b1);
        nap(2'h2, 1'b1);
        check("bod_off", brownout_detector_en, 1'b0);
        wk[4] <= 1'b1;
        wake;
        check("bod_wake", n >= 600 && n < 700, 1'b1);
        check("bod_on", brownout_detector_en, 1'b1);
        give_verdict;
    end
endmodule
`default_nettype wire
